// >>> sim/sic_props.sv
// port assertions for the spi interrupt and divider block
`timescale 1ns/10ps
`default_nettype none
module sic_props (
  input wire logic clock, // core clock
  input wire logic rst_b, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr, // apb error
  input wire logic rx_byte_valid, // byte offered
  input wire logic rx_byte_ready, // queue room
  input wire logic rxq_bus_err_stb, // bus overrun
  input wire logic master_mode, // master select
  input wire logic sclk_out, // serial clock
  input wire logic sclk_oe, // clock enable
  input wire logic irq // interrupt
);
  // ****
  // shadow of written registers
  // ****
  logic [10:0] mask_q;
  logic [31:0] div_q;
  logic acc_rd;
  assign acc_rd = psel && penable && !pwrite;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= 11'h7FF;
    end else if (psel && penable && pwrite && paddr == 8'h04) begin
      mask_q <= pwdata[10:0];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 32'h00000002;
    end else if (psel && penable && pwrite && paddr == 8'h0C) begin
      div_q <= pwdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_slave; !master_mode |=> !sclk_oe && !sclk_out; endproperty
  property p_div2; sclk_oe && $past(sclk_oe) && div_q == 32'h2 && $past(div_q) == 32'h2
    |-> sclk_out != $past(sclk_out); endproperty
  property p_masked; mask_q == 11'h7FF && $past(mask_q) == 11'h7FF |-> !irq; endproperty
  property p_over; (rx_byte_valid && !rx_byte_ready && !mask_q[9]) ##1 !mask_q[9] |=> irq;
  endproperty
  property p_bus_err; (rxq_bus_err_stb && !mask_q[6]) ##1 !mask_q[6] |=> irq; endproperty
  property p_decode; psel && penable
    |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}); endproperty
  property p_rd_clr; acc_rd && paddr == 8'h08 |-> prdata == 32'h0; endproperty
  property p_rd_mask; acc_rd && paddr == 8'h04 |-> prdata == {21'h0, mask_q}; endproperty
  property p_rd_div; acc_rd && paddr == 8'h0C |-> prdata == div_q; endproperty
  a_slave: assert property (p_slave) else $error("clock driven in slave mode");
  a_div2: assert property (p_div2) else $error("divide by two broken");
  a_masked: assert property (p_masked) else $error("irq while all masked");
  a_over: assert property (p_over) else $error("no irq on overrun");
  a_bus_err: assert property (p_bus_err) else $error("no irq on bus error");
  a_decode: assert property (p_decode) else $error("bad error response");
  a_rd_clr: assert property (p_rd_clr) else $error("clear reads nonzero");
  a_rd_mask: assert property (p_rd_mask) else $error("mask readback wrong");
  a_rd_div: assert property (p_rd_div) else $error("divider readback wrong");
  c_irq: cover property ($rose(irq));
  c_err: cover property (psel && penable && pslverr);
  c_clk: cover property ($rose(sclk_oe));
endmodule // sic_props
bind sic_top sic_props sic_props_i (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pslverr, .rx_byte_valid, .rx_byte_ready, .rxq_bus_err_stb, .master_mode,
  .sclk_out, .sclk_oe, .irq);
`default_nettype wire

// >>> sim/sic_slave_model.sv
// serial-side byte source standing in for an attached slave device
`timescale 1ns/10ps
`default_nettype none
module sic_slave_model (
  input wire logic clock, // core clock
  input wire logic rst_b, // reset, active low
  input wire logic start, // load a burst
  input wire logic [3:0] nbytes, // burst length
  input wire logic slow, // idle a cycle after each byte
  input wire logic rx_byte_ready, // queue room
  output logic rx_byte_valid, // byte offered
  output logic [7:0] rx_byte_data, // offered byte
  output logic busy // burst pending
);
  logic [3:0] left_q, idx_q;
  logic gap_q;
  logic [7:0] last_q;
  assign busy = left_q != 4'h0;
  assign rx_byte_valid = busy && !gap_q;
  // two poll bytes, start token, payload; idle line shows the inverse
  assign rx_byte_data = !rx_byte_valid ? ~last_q : idx_q < 4'h2 ? 8'hFF :
    idx_q == 4'h2 ? 8'hFE : {4'h0, idx_q};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 4'h0;
      idx_q <= 4'h0;
      gap_q <= 1'b0;
      last_q <= 8'h00;
    end else if (start) begin
      left_q <= nbytes;
      idx_q <= 4'h0;
    end else if (rx_byte_valid && rx_byte_ready) begin
      left_q <= left_q - 4'h1;
      idx_q <= idx_q + 4'h1;
      gap_q <= slow;
      last_q <= rx_byte_data;
    end else begin
      gap_q <= 1'b0;
    end
  end
endmodule // sic_slave_model
`default_nettype wire

// >>> sim/tb_sic_top.sv
// self-checking bench for the spi interrupt and clock divider block
`timescale 1ns/10ps
`default_nettype none
module tb_sic_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, rx_byte_valid, rx_byte_ready, rxq_out_valid, busy;
  logic [7:0] rx_byte_data, rxq_out_data;
  logic rxq_out_ready = 1'b0, rxq_acc_stb = 1'b0, master_mode = 1'b0;
  logic [1:0] rxq_acc_size = 2'h0;
  logic [2:0] err_stb = 3'h0;
  logic [3:0] txq_level = 4'h4, txq_half_level = 4'h4, rxq_half_level = 4'h4, nbytes = 4'h0;
  logic sclk_out, sclk_oe, irq;
  logic [7:0] seq [9] = '{8'hFF, 8'hFF, 8'hFE, 8'hFF, 8'hFF, 8'hFE, 8'h03, 8'h04, 8'h05};
  logic [3:0] lv [3] = '{4'h7, 4'h3, 4'h0};
  int mismatches = 0, compares = 0, n;
  always #2 clock = ~clock;
  sic_top sic_top_i (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_byte_valid, .rx_byte_data, .rx_byte_ready, .rxq_out_valid,
    .rxq_out_data, .rxq_out_ready, .rxq_acc_stb, .rxq_acc_size, .rxq_bus_err_stb(err_stb[0]),
    .txq_bus_err_stb(err_stb[1]), .txq_line_err_stb(err_stb[2]), .txq_level, .txq_half_level,
    .rxq_half_level, .master_mode, .sclk_out, .sclk_oe, .irq);
  sic_slave_model sic_slave_model_i (.clock, .rst_b, .start, .nbytes, .slow, .rx_byte_ready,
    .rx_byte_valid, .rx_byte_data, .busy);
  // ****
  // access and check tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk(e, eexp, "error response");
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic burst(input logic [3:0] k, input logic s);
    int w;
    @(posedge clock);
    start <= 1'b1;
    nbytes <= k;
    slow <= s;
    @(posedge clock);
    start <= 1'b0;
    w = 0;
    // returns when the burst is done or the receive queue refuses bytes
    @(negedge clock);
    while (busy === 1'b1 && rx_byte_ready === 1'b1 && w < 50) begin
      @(negedge clock);
      w++;
    end
    chk(w < 50, 1'b1, "burst stalled");
  endtask
  // cycles between two rising serial clock edges, and high cycles among them
  task automatic period(input int ep, input int eh);
    int r, p, h;
    logic prv;
    r = 0;
    p = 0;
    h = 0;
    prv = 1'b1;
    repeat (64) begin
      @(negedge clock);
      if (r == 1) begin
        p++;
        h += int'(sclk_out === 1'b1);
      end
      if (prv === 1'b0 && sclk_out === 1'b1) r++;
      prv = sclk_out;
    end
    chk(p, ep, "clock period");
    chk(h, eh, "clock high time");
    @(posedge clock);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    conclude();
  end
  // ****
  // test sequence
  // ****
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rdc(8'h04, 32'h7FF, 1'b0);
    rdc(8'h0C, 32'h2, 1'b0);
    rdc(8'h00, 32'h0, 1'b0);
    rdc(8'h08, 32'h0, 1'b0);
    rdc(8'h10, 32'h0, 1'b1);
    chk(pready, 1'b1, "no wait states");
    $display("test reset done");
    burst(4'h3, 1'b0);
    cyc(3);
    chk(irq, 1'b0, "irq masked");
    rdc(8'h00, 32'h408, 1'b0);
    // unmask nonempty, token, bus receive error and both serial errors
    wr(8'h04, 32'h0B7);
    cyc(2);
    chk(irq, 1'b1, "irq unmasked");
    wr(8'h08, 32'h0);
    rdc(8'h00, 32'h408, 1'b0);
    wr(8'h08, 32'h408);
    cyc(2);
    chk(irq, 1'b0, "irq after clear");
    $display("test token done");
    burst(4'h6, 1'b1);
    cyc(1);
    chk(rx_byte_ready, 1'b0, "ready when full");
    rdc(8'h00, 32'h630, 1'b0);
    @(posedge clock);
    rxq_out_ready <= 1'b1;
    n = 0;
    repeat (40) begin
      @(negedge clock);
      if (rxq_out_valid === 1'b1 && n < 9) begin
        chk(rxq_out_data, seq[n], "queue order");
        n++;
      end
    end
    @(posedge clock);
    rxq_out_ready <= 1'b0;
    chk(n, 9, "bytes drained");
    $display("test fill done");
    txq_level <= 4'h8;
    wr(8'h08, 32'h7FF);
    foreach (lv[i]) begin
      @(posedge clock);
      txq_level <= lv[i];
    end
    cyc(2);
    rdc(8'h00, 32'h7, 1'b0);
    for (int k = 0; k < 3; k++) begin
      wr(8'h08, 32'h7FF);
      @(posedge clock);
      err_stb[k] <= 1'b1;
      @(posedge clock);
      err_stb[k] <= 1'b0;
      rdc(8'h00, 32'h40 << k, 1'b0);
    end
    chk(irq, 1'b1, "irq on error");
    wr(8'h04, 32'h7FF);
    cyc(2);
    chk(irq, 1'b0, "irq masked again");
    wr(8'h08, 32'h7FF);
    @(posedge clock);
    rxq_acc_stb <= 1'b1;
    @(posedge clock);
    rxq_acc_size <= 2'h2;
    @(posedge clock);
    rxq_acc_stb <= 1'b0;
    rdc(8'h00, 32'h40, 1'b0);
    $display("test events done");
    @(posedge clock);
    master_mode <= 1'b1;
    period(2, 1);
    // software keeps the divisor above one
    wr(8'h0C, 32'h5);
    period(5, 2);
    rdc(8'h0C, 32'h5, 1'b0);
    master_mode <= 1'b0;
    cyc(2);
    chk({sclk_oe, sclk_out}, 2'b00, "slave clock idle");
    $display("test divider done");
    conclude();
  end
endmodule // tb_sic_top
`default_nettype wire

// >>> src/sic_fifo.sv
// parameterised valid/ready fifo built from flip-flops
`timescale 1ns/10ps
`default_nettype none
module sic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic in_valid, // write offered
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic in_ready, // space available
  output logic out_valid, // data available
  output logic [WIDTH-1:0] out_data, // head entry
  input wire logic out_ready, // reader takes head
  output logic [$clog2(DEPTH+1)-1:0] count // entries held
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH-1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign count = cnt_q;
  assign out_data = mem_q[rd_q];

  // storage, one flop row per entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          mem_q[gi] <= '0;
        end else if (push && wr_q == PW'(gi)) begin
          mem_q[gi] <= in_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // sic_fifo
`default_nettype wire

// >>> src/sic_pkg.sv
// constants shared by the spi interrupt and clock divider block
//
// Overview of operation
// - set bit 6 on APB-side receive queue error
// - wider access off byte zero is misaligned
// - set bit 5 when receive queue fills
// - set bit 4 when receive level passes half
// - set bit 3 when receive queue leaves empty
// - set bit 2 when transmit queue leaves full
// - set bit 1 when transmit level drops below half
// - set bit 0 when transmit queue empties
// - mask bits 10-0, one blocks, reset ones
// - writing one to clear register clears source
// - master clock is PLL clock divided by divider
// - divider only used in master mode
// - raw source register readable, unmasked
// - set bit 10 on FF then FE received
// - set bits 9/8 on serial-side queue errors
// - set bit 7 on APB-side transmit queue error
package sic_pkg;

  // ****************************************************
  // bus geometry and register offsets
  // ****************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 11;
  localparam logic [7:0] OFS_RAW = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CLEAR = 8'h08;
  localparam logic [7:0] OFS_DIV = 8'h0C;
  localparam logic [10:0] MASK_RST = 11'h7FF;
  localparam logic [10:0] RAW_RST = 11'h000;
  localparam logic [31:0] DIV_RST = 32'h00000002;
  localparam logic [31:0] DIV_MIN = 32'h00000002;

  // ****************************************************
  // interrupt source bit positions
  // ****************************************************
  localparam int SRC_XMIT_EMPTY = 0;
  localparam int SRC_XMIT_BELOW_HALF = 1;
  localparam int SRC_XMIT_NOT_FULL = 2;
  localparam int SRC_RECV_NONEMPTY = 3;
  localparam int SRC_RECV_ABOVE_HALF = 4;
  localparam int SRC_RECV_FULL = 5;
  localparam int SRC_RECV_BUS_ERR = 6;
  localparam int SRC_XMIT_BUS_ERR = 7;
  localparam int SRC_XMIT_LINE_ERR = 8;
  localparam int SRC_RECV_LINE_ERR = 9;
  localparam int SRC_START_TOKEN = 10;

  // ****************************************************
  // queues, tokens and access sizes
  // ****************************************************
  localparam int BYTE_W = 8;
  localparam int LVL_W = 4;
  localparam int RECV_DEPTH = 8;
  localparam logic [3:0] XMIT_DEPTH = 4'h8;
  localparam logic [3:0] LVL_EMPTY = 4'h0;
  localparam logic [7:0] TOKEN_IDLE = 8'hFF;
  localparam logic [7:0] TOKEN_START = 8'hFE;
  localparam logic [1:0] PTR_ZERO = 2'h0;
  localparam logic [1:0] STEP_BYTE = 2'h1;
  localparam logic [1:0] STEP_HALF = 2'h2;
  localparam logic [1:0] STEP_WORD = 2'h0;

  typedef enum logic [1:0] {
    SIC_SZ_BYTE = 2'h0,
    SIC_SZ_HALF = 2'h1,
    SIC_SZ_WORD = 2'h2
  } sic_size_e;

  typedef enum logic [1:0] {
    SIC_CLK_IDLE = 2'h1,
    SIC_CLK_RUN = 2'h2
  } sic_clk_state_e;

endpackage

// >>> src/sic_top.sv
// spi interrupt sources, mask/clear registers and serial clock divider
`timescale 1ns/10ps
`default_nettype none
module sic_top (
  input wire logic clock, // 250 MHz core and pll clock
  input wire logic rst_b, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic rx_byte_valid, // serial side byte received
  input wire logic [7:0] rx_byte_data, // received byte
  output logic rx_byte_ready, // receive queue has room
  output logic rxq_out_valid, // receive queue head valid
  output logic [7:0] rxq_out_data, // receive queue head
  input wire logic rxq_out_ready, // bus side takes head
  input wire logic rxq_acc_stb, // bus side queue access
  input wire logic [1:0] rxq_acc_size, // access width code
  input wire logic rxq_bus_err_stb, // bus side receive overrun
  input wire logic txq_bus_err_stb, // bus side transmit error
  input wire logic txq_line_err_stb, // serial side transmit underrun
  input wire logic [3:0] txq_level, // transmit queue fill level
  input wire logic [3:0] txq_half_level, // transmit half threshold
  input wire logic [3:0] rxq_half_level, // receive half threshold
  input wire logic master_mode, // one when master
  output logic sclk_out, // serial clock drive value
  output logic sclk_oe, // serial clock drive enable
  output logic irq // interrupt request, active high
);

  // ****************************************************
  // declarations
  // ****************************************************
  logic [10:0] raw_q;
  logic [10:0] raw_d;
  logic [10:0] mask_q;
  logic [31:0] div_q;
  logic [10:0] evt;
  logic [10:0] clr;
  logic irq_q;
  logic [31:0] rdata_q;
  logic slverr_q;
  logic setup;
  logic wr_acc;
  logic addr_ok;
  logic [3:0] rxq_count;
  logic rxq_in_ready;
  logic rx_push;
  logic recv_queue_full_evt;
  logic recv_queue_above_half_evt;
  logic recv_queue_nonempty_evt;
  logic xmit_queue_not_full_evt;
  logic xmit_queue_below_half_evt;
  logic xmit_queue_empty_evt;
  logic rx_full_c;
  logic rx_above_c;
  logic rx_empty_c;
  logic tx_full_c;
  logic tx_below_c;
  logic tx_empty_c;
  logic rx_full_q;
  logic rx_above_q;
  logic rx_empty_q;
  logic tx_full_q;
  logic tx_below_q;
  logic tx_empty_q;
  logic [1:0] byte_ptr_q;
  logic [1:0] ptr_step;
  logic misaligned;
  logic last_idle_q;
  logic token_evt;
  logic line_overrun;
  logic [31:0] div_eff;
  logic [31:0] sclk_cnt_q;
  logic [31:0] half_div;
  logic sclk_q;
  sic_pkg::sic_clk_state_e clk_st_q;

  // ****************************************************
  // apb slave
  // ****************************************************
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = slverr_q;

  always_comb begin
    case (paddr)
      sic_pkg::OFS_RAW: addr_ok = 1'b1;
      sic_pkg::OFS_MASK: addr_ok = 1'b1;
      sic_pkg::OFS_CLEAR: addr_ok = 1'b1;
      sic_pkg::OFS_DIV: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // read data and error are captured in the setup phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
      slverr_q <= 1'b0;
    end else if (setup) begin
      slverr_q <= ~addr_ok;
      if (pwrite) begin
        rdata_q <= '0;
      end else begin
        case (paddr)
          sic_pkg::OFS_RAW: rdata_q <= {21'h000000, raw_q};
          sic_pkg::OFS_MASK: rdata_q <= {21'h000000, mask_q};
          sic_pkg::OFS_DIV: rdata_q <= div_q;
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  // ****************************************************
  // mask and divider registers
  // ****************************************************
  // mask resets to all ones
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= sic_pkg::MASK_RST;
    end else if (wr_acc && paddr == sic_pkg::OFS_MASK) begin
      mask_q <= pwdata[10:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= sic_pkg::DIV_RST;
    end else if (wr_acc && paddr == sic_pkg::OFS_DIV) begin
      div_q <= pwdata;
    end
  end

  // write one clears, zero no effect
  assign clr = (wr_acc && paddr == sic_pkg::OFS_CLEAR) ? pwdata[10:0] : '0;

  // ****************************************************
  // receive queue
  // ****************************************************
  sic_fifo #(
    .WIDTH(sic_pkg::BYTE_W),
    .DEPTH(sic_pkg::RECV_DEPTH)
  ) u_rxq (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(rx_byte_valid),
    .in_data(rx_byte_data),
    .in_ready(rxq_in_ready),
    .out_valid(rxq_out_valid),
    .out_data(rxq_out_data),
    .out_ready(rxq_out_ready),
    .count(rxq_count)
  );

  assign rx_byte_ready = rxq_in_ready;
  assign rx_push = rx_byte_valid & rxq_in_ready;
  // byte offered while full is a serial-side overrun
  assign line_overrun = rx_byte_valid & ~rxq_in_ready;

  // ****************************************************
  // level conditions and their edges
  // ****************************************************
  assign rx_full_c = (rxq_count == sic_pkg::XMIT_DEPTH);
  assign rx_above_c = (rxq_count > rxq_half_level);
  assign rx_empty_c = (rxq_count == sic_pkg::LVL_EMPTY);
  assign tx_full_c = (txq_level == sic_pkg::XMIT_DEPTH);
  assign tx_below_c = (txq_level < txq_half_level);
  assign tx_empty_c = (txq_level == sic_pkg::LVL_EMPTY);

  // previous conditions; reset values match an idle, empty pair of queues
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_full_q <= 1'b0;
      rx_above_q <= 1'b0;
      rx_empty_q <= 1'b1;
      tx_full_q <= 1'b0;
      tx_below_q <= 1'b1;
      tx_empty_q <= 1'b1;
    end else begin
      rx_full_q <= rx_full_c;
      rx_above_q <= rx_above_c;
      rx_empty_q <= rx_empty_c;
      tx_full_q <= tx_full_c;
      tx_below_q <= tx_below_c;
      tx_empty_q <= tx_empty_c;
    end
  end

  assign recv_queue_full_evt = rx_full_c & ~rx_full_q;
  assign recv_queue_above_half_evt = rx_above_c & ~rx_above_q;
  assign recv_queue_nonempty_evt = ~rx_empty_c & rx_empty_q;
  assign xmit_queue_not_full_evt = ~tx_full_c & tx_full_q;
  assign xmit_queue_below_half_evt = tx_below_c & ~tx_below_q;
  assign xmit_queue_empty_evt = tx_empty_c & ~tx_empty_q;

  // ****************************************************
  // bus side byte pointer
  // ****************************************************
  always_comb begin
    case (rxq_acc_size)
      sic_pkg::SIC_SZ_BYTE: ptr_step = sic_pkg::STEP_BYTE;
      sic_pkg::SIC_SZ_HALF: ptr_step = sic_pkg::STEP_HALF;
      default: ptr_step = sic_pkg::STEP_WORD;
    endcase
  end

  // wider access with pointer off byte zero
  assign misaligned = rxq_acc_stb & (rxq_acc_size != sic_pkg::SIC_SZ_BYTE)
                      & (byte_ptr_q != sic_pkg::PTR_ZERO);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      byte_ptr_q <= sic_pkg::PTR_ZERO;
    end else if (rxq_acc_stb) begin
      byte_ptr_q <= byte_ptr_q + ptr_step;
    end
  end

  // ****************************************************
  // start token watch
  // ****************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      last_idle_q <= 1'b0;
    end else if (rx_push) begin
      last_idle_q <= (rx_byte_data == sic_pkg::TOKEN_IDLE);
    end
  end

  // idle pattern followed by start token
  assign token_evt = rx_push & last_idle_q & (rx_byte_data == sic_pkg::TOKEN_START);

  // ****************************************************
  // raw sources and interrupt
  // ****************************************************
  always_comb begin
    evt = '0;
    evt[sic_pkg::SRC_XMIT_EMPTY] = xmit_queue_empty_evt;
    evt[sic_pkg::SRC_XMIT_BELOW_HALF] = xmit_queue_below_half_evt;
    evt[sic_pkg::SRC_XMIT_NOT_FULL] = xmit_queue_not_full_evt;
    evt[sic_pkg::SRC_RECV_NONEMPTY] = recv_queue_nonempty_evt;
    evt[sic_pkg::SRC_RECV_ABOVE_HALF] = recv_queue_above_half_evt;
    evt[sic_pkg::SRC_RECV_FULL] = recv_queue_full_evt;
    // bus side receive overrun or misalignment
    evt[sic_pkg::SRC_RECV_BUS_ERR] = rxq_bus_err_stb | misaligned;
    evt[sic_pkg::SRC_XMIT_BUS_ERR] = txq_bus_err_stb;
    evt[sic_pkg::SRC_XMIT_LINE_ERR] = txq_line_err_stb;
    evt[sic_pkg::SRC_RECV_LINE_ERR] = line_overrun;
    evt[sic_pkg::SRC_START_TOKEN] = token_evt;
  end

  // sticky, a new event wins over a clear
  assign raw_d = (raw_q & ~clr) | evt;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      raw_q <= sic_pkg::RAW_RST;
    end else begin
      raw_q <= raw_d;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(raw_q & ~mask_q);
    end
  end

  assign irq = irq_q;

  // ****************************************************
  // serial clock divider
  // ****************************************************
  // illegal divisors are held at the minimum
  assign div_eff = (div_q < sic_pkg::DIV_MIN) ? sic_pkg::DIV_MIN : div_q;
  assign half_div = div_eff >> 1;

  // divider runs only in master mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clk_st_q <= sic_pkg::SIC_CLK_IDLE;
    end else begin
      case (clk_st_q)
        sic_pkg::SIC_CLK_IDLE: begin
          if (master_mode) begin
            clk_st_q <= sic_pkg::SIC_CLK_RUN;
          end
        end
        sic_pkg::SIC_CLK_RUN: begin
          if (!master_mode) begin
            clk_st_q <= sic_pkg::SIC_CLK_IDLE;
          end
        end
        default: clk_st_q <= sic_pkg::SIC_CLK_IDLE;
      endcase
    end
  end

  // one serial period per divisor cycles
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_cnt_q <= '0;
      sclk_q <= 1'b0;
    end else if (clk_st_q == sic_pkg::SIC_CLK_RUN && master_mode) begin
      if (sclk_cnt_q >= div_eff - 32'h00000001) begin
        sclk_cnt_q <= '0;
      end else begin
        sclk_cnt_q <= sclk_cnt_q + 32'h00000001;
      end
      sclk_q <= (sclk_cnt_q < half_div);
    end else begin
      sclk_cnt_q <= '0;
      sclk_q <= 1'b0;
    end
  end

  assign sclk_out = sclk_q;
  assign sclk_oe = (clk_st_q == sic_pkg::SIC_CLK_RUN);

endmodule // sic_top
`default_nettype wire
